// ---- src/single_wire_bus_master.sv ----
// single-wire open-drain bus master with an APB register port
// assumes pclk at 200 MHz, line pin pulled up outside, and a dma_done
// pulse from the system DMA engine on the same clock
`timescale 1ns/100ps

// Overview of operation
// R1: transaction takes any mix of reset/write/read
// R2: write phase finishes before read phase starts
// R3: bit count 1..32, only those bits move
// R4: software checks idle before starting; busy start ignored
// R5: flag reset done and operation done
// R6: flag missing presence pulse after reset
// R7: flag line held low by someone else
// R8: flag completion of DMA sequence
// R9: raw and masked interrupt status readable
// R10: flags stay until software clears them
// R11: read bits default to one
// R12: busy, no-presence and stuck level status bits
// R13: selectable fast timing and late sampling
// R14: bits move least significant first
module single_wire_bus_master #(
  parameter int TICK_CYC = owire_pkg::TICK_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        line_i,
  output logic             line_o,
  output logic             line_oe,
  input  wire logic        dma_done,
  output logic             irq
);
  // ---- registers ----
  logic [2:0]  op_q;          // requested operations of this transaction
  logic [5:0]  bitcnt_q;      // bits to move, 1..32
  logic        fast_timing_select;
  logic        late_sample_select;
  logic [31:0] tx_q;          // data to write
  logic [31:0] rx_q;          // data read
  logic [4:0]  ris_q;         // raw sticky flags
  logic [4:0]  mask_q;        // interrupt enables
  logic        nopres_q;      // level: last reset saw nobody
  logic        stuck_q;       // level: last check found line low
  logic        present_q;     // presence seen in current reset slot
  logic [4:0]  ev_q;          // one-cycle event pulses into ris
  owire_pkg::seq_state_e state_q;
  logic [11:0] tcnt_q;        // ticks into current slot
  logic [4:0]  bidx_q;        // current bit index

  // ---- sensed line and tick ----
  logic line_s;  // synchronised line level
  logic tick;    // timing enable pulse

  line_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (line_i),
    .dout_q  (line_s)
  );

  tick_gen #(.DIV(TICK_CYC)) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick_q  (tick)
  );

  // ---- apb decode ----
  logic        acc;         // access phase with answer due this edge
  logic        wr_en;       // write takes effect now
  logic        hit_ctrl;
  logic        hit_cfg;
  logic        hit_tx;
  logic        hit_rx;
  logic        hit_stat;
  logic        hit_ris;
  logic        hit_mask;
  logic        hit_mis;
  logic        mapped;
  logic [31:0] rd_mux;      // read data selected by address
  logic        bus_active_flag;
  logic [4:0]  mis;         // masked status
  logic [5:0]  cnt_req;     // requested bit count, clamped

  // a single wait state: pready rises in the second access cycle, so the
  // read mux is sampled while the address is known stable
  assign acc      = psel & penable & ~pready;
  assign wr_en    = psel & penable & pready & pwrite & ~pslverr;
  assign hit_ctrl = (paddr == owire_pkg::CTRL_OFS);
  assign hit_cfg  = (paddr == owire_pkg::CFG_OFS);
  assign hit_tx   = (paddr == owire_pkg::TXDATA_OFS);
  assign hit_rx   = (paddr == owire_pkg::RXDATA_OFS);
  assign hit_stat = (paddr == owire_pkg::STATUS_OFS);
  assign hit_ris  = (paddr == owire_pkg::RIS_OFS);
  assign hit_mask = (paddr == owire_pkg::MASK_OFS);
  assign hit_mis  = (paddr == owire_pkg::MIS_OFS);
  assign mapped   = hit_ctrl | hit_cfg | hit_tx | hit_rx | hit_stat |
                    hit_ris | hit_mask | hit_mis;

  assign bus_active_flag = (state_q != owire_pkg::ST_IDLE); // R12
  assign mis = ris_q & mask_q; // R9

  // read mux, unused bits read zero
  always_comb begin
    rd_mux = owire_pkg::ZERO_RST;
    if (hit_ctrl) begin
      rd_mux[2:0]   = op_q;
      rd_mux[owire_pkg::BITCNT_LSB +: owire_pkg::BITCNT_W] = bitcnt_q;
    end else if (hit_cfg) begin
      rd_mux[owire_pkg::FAST_BIT] = fast_timing_select;
      rd_mux[owire_pkg::LATE_BIT] = late_sample_select;
    end else if (hit_tx) begin
      rd_mux = tx_q;
    end else if (hit_rx) begin
      rd_mux = rx_q;
    end else if (hit_stat) begin
      rd_mux[owire_pkg::BUSY_BIT]   = bus_active_flag; // R12
      rd_mux[owire_pkg::NOPRES_BIT] = nopres_q;        // R12
      rd_mux[owire_pkg::STUCK_BIT]  = stuck_q;         // R12
    end else if (hit_ris) begin
      rd_mux[4:0] = ris_q;  // R9
    end else if (hit_mask) begin
      rd_mux[4:0] = mask_q;
    end else if (hit_mis) begin
      rd_mux[4:0] = mis;    // R9
    end
  end

  // apb answer: ready, error for unmapped, registered read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= owire_pkg::ZERO_RST;
    end else begin
      pready  <= acc;
      pslverr <= acc & ~mapped;
      if (acc) begin
        prdata <= rd_mux;
      end
    end
  end

  // ---- start of a transaction ----
  logic start;    // accepted control write with some operation
  logic [2:0] op_w;

  // a zero count is taken as one, anything above 32 as 32
  assign cnt_req = (pwdata[owire_pkg::BITCNT_LSB +: owire_pkg::BITCNT_W]
                    == 6'h00) ? 6'h01 :
                   (pwdata[owire_pkg::BITCNT_LSB +: owire_pkg::BITCNT_W]
                    > owire_pkg::BITCNT_MAX) ? owire_pkg::BITCNT_MAX :
                   pwdata[owire_pkg::BITCNT_LSB +: owire_pkg::BITCNT_W]; // R3
  assign op_w  = pwdata[2:0];
  // a start while busy is dropped; software is expected to poll busy
  assign start = wr_en & hit_ctrl & (op_w != 3'b000) &
                 ~bus_active_flag; // R4 R1

  // control and config registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q               <= 3'b000;
      bitcnt_q           <= owire_pkg::BITCNT_MAX;
      fast_timing_select <= 1'b0;
      late_sample_select <= 1'b0;
      tx_q               <= owire_pkg::ZERO_RST;
      mask_q             <= 5'h00;
    end else begin
      if (start) begin
        op_q     <= op_w;     // R1
        bitcnt_q <= cnt_req;  // R3
      end
      if (wr_en & hit_cfg) begin
        fast_timing_select <= pwdata[owire_pkg::FAST_BIT]; // R13
        late_sample_select <= pwdata[owire_pkg::LATE_BIT]; // R13
      end
      if (wr_en & hit_tx) begin
        tx_q <= pwdata;
      end
      if (wr_en & hit_mask) begin
        mask_q <= pwdata[4:0];
      end
    end
  end

  // ---- timing selection ----
  logic [11:0] t_rlow;   // reset low length
  logic [11:0] t_pres;   // presence sample point
  logic [11:0] t_rslot;  // reset slot end
  logic [11:0] t_slot;   // bit slot end
  logic [11:0] t_w1;     // low length for a one
  logic [11:0] t_w0;     // low length for a zero
  logic [11:0] t_rdlow;  // low length opening a read slot
  logic [11:0] t_smp;    // read sample point
  logic [11:0] t_low;    // low length of the current slot
  logic [11:0] t_end;    // end of the current slot
  logic        last_bit; // current bit is the final one

  assign t_rlow  = fast_timing_select ? owire_pkg::FST_RST_LOW_T
                                      : owire_pkg::STD_RST_LOW_T;  // R13
  assign t_pres  = fast_timing_select ? owire_pkg::FST_PRES_T
                                      : owire_pkg::STD_PRES_T;     // R13
  assign t_rslot = fast_timing_select ? owire_pkg::FST_RST_SLOT_T
                                      : owire_pkg::STD_RST_SLOT_T; // R13
  assign t_slot  = fast_timing_select ? owire_pkg::FST_SLOT_T
                                      : owire_pkg::STD_SLOT_T;     // R13
  assign t_w1    = fast_timing_select ? owire_pkg::FST_W1_T
                                      : owire_pkg::STD_W1_T;
  assign t_w0    = fast_timing_select ? owire_pkg::FST_W0_T
                                      : owire_pkg::STD_W0_T;
  assign t_rdlow = fast_timing_select ? owire_pkg::FST_RDLOW_T
                                      : owire_pkg::STD_RDLOW_T;
  assign t_smp   = fast_timing_select ?
                   (late_sample_select ? owire_pkg::FST_LATE_T
                                       : owire_pkg::FST_SMP_T) :
                   (late_sample_select ? owire_pkg::STD_LATE_T
                                       : owire_pkg::STD_SMP_T);    // R13

  // low time and end of slot for whatever slot is running
  assign t_low = (state_q == owire_pkg::ST_RESET) ? t_rlow :
                 (state_q == owire_pkg::ST_READ)  ? t_rdlow :
                 (tx_q[bidx_q] ? t_w1 : t_w0); // R14
  assign t_end = (state_q == owire_pkg::ST_RESET) ? t_rslot : t_slot;
  assign last_bit = ({1'b0, bidx_q} == bitcnt_q - 6'h01); // R3

  // ---- bus sequencer ----
  // tick 0 of each slot is a check that the line is high before we
  // pull it; a low line there cannot be ours and aborts the transaction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= owire_pkg::ST_IDLE;
      tcnt_q    <= 12'h000;
      bidx_q    <= 5'h00;
      rx_q      <= owire_pkg::RXDATA_RST;
      present_q <= 1'b0;
      nopres_q  <= 1'b0;
      stuck_q   <= 1'b0;
      ev_q      <= 5'h00;
    end else begin
      ev_q <= 5'h00;
      ev_q[owire_pkg::IRQ_DMA_BIT] <= dma_done; // R8
      case (state_q)
        owire_pkg::ST_IDLE: begin
          if (start) begin
            tcnt_q    <= 12'h000;
            bidx_q    <= 5'h00;
            present_q <= 1'b0;
            nopres_q  <= 1'b0;
            stuck_q   <= 1'b0;
            if (op_w[owire_pkg::OP_READ_BIT]) begin
              rx_q <= owire_pkg::RXDATA_RST; // R11
            end
            // order: reset, then write, then read
            if (op_w[owire_pkg::OP_RESET_BIT]) begin
              state_q <= owire_pkg::ST_RESET;
            end else if (op_w[owire_pkg::OP_WRITE_BIT]) begin
              state_q <= owire_pkg::ST_WRITE;
            end else begin
              state_q <= owire_pkg::ST_READ;
            end
          end
        end
        default: begin
          if (tick) begin
            if (tcnt_q == 12'h000 && !line_s) begin
              // line low before we drive it: held by a slave or short
              stuck_q <= 1'b1;                       // R7
              ev_q[owire_pkg::IRQ_STUCK_BIT] <= 1'b1; // R7
              state_q <= owire_pkg::ST_IDLE;
            end else if (tcnt_q == t_end) begin
              tcnt_q <= 12'h000;
              if (state_q == owire_pkg::ST_RESET) begin
                ev_q[owire_pkg::IRQ_RESET_BIT] <= 1'b1; // R5
                if (!present_q) begin
                  // no one answered, so nothing follows the reset
                  nopres_q <= 1'b1;                        // R6
                  ev_q[owire_pkg::IRQ_NOPRES_BIT] <= 1'b1; // R6
                  state_q <= owire_pkg::ST_IDLE;
                end else if (op_q[owire_pkg::OP_WRITE_BIT]) begin
                  state_q <= owire_pkg::ST_WRITE;
                end else if (op_q[owire_pkg::OP_READ_BIT]) begin
                  state_q <= owire_pkg::ST_READ;
                end else begin
                  state_q <= owire_pkg::ST_IDLE;
                end
              end else if (!last_bit) begin
                bidx_q <= bidx_q + 5'h01; // R14
              end else if (state_q == owire_pkg::ST_WRITE &&
                           op_q[owire_pkg::OP_READ_BIT]) begin
                bidx_q  <= 5'h00;
                state_q <= owire_pkg::ST_READ; // R2
              end else begin
                ev_q[owire_pkg::IRQ_OPDONE_BIT] <= 1'b1; // R5
                state_q <= owire_pkg::ST_IDLE;
              end
            end else begin
              tcnt_q <= tcnt_q + 12'h001;
              if (state_q == owire_pkg::ST_RESET && tcnt_q == t_pres &&
                  !line_s) begin
                present_q <= 1'b1; // R6
              end
              if (state_q == owire_pkg::ST_READ && tcnt_q == t_smp) begin
                rx_q[bidx_q] <= line_s; // R14 R11
              end
            end
          end
        end
      endcase
    end
  end

  // ---- line driver ----
  // open drain: data is always low, only the enable moves
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_o  <= 1'b0;
      line_oe <= 1'b0;
    end else begin
      line_o  <= 1'b0;
      line_oe <= bus_active_flag && tcnt_q != 12'h000 &&
                 tcnt_q <= t_low;
    end
  end

  // ---- interrupt flags ----
  // a new event wins over a clear written in the same cycle
  logic [4:0] clr; // write-one-to-clear mask

  assign clr = (wr_en & hit_ris) ? pwdata[4:0] : 5'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ris_q <= 5'h00;
      irq   <= 1'b0;
    end else begin
      ris_q <= (ris_q & ~clr) | ev_q; // R10
      irq   <= |mis;                  // R9
    end
  end
endmodule // single_wire_bus_master

// ---- inc/owire_pkg.sv ----
// constants for the single-wire bus master: register map, fields,
// interrupt bits, reset values and slot timing
// assumes a 200 MHz pclk; all timing is counted in 250 ns ticks
package owire_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] CFG_OFS    = 8'h04;
  localparam logic [7:0] TXDATA_OFS = 8'h08;
  localparam logic [7:0] RXDATA_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] RIS_OFS    = 8'h14;
  localparam logic [7:0] MASK_OFS   = 8'h18;
  localparam logic [7:0] MIS_OFS    = 8'h1c;
  // control fields
  localparam int OP_RESET_BIT = 0;
  localparam int OP_WRITE_BIT = 1;
  localparam int OP_READ_BIT  = 2;
  localparam int BITCNT_LSB   = 16;
  localparam int BITCNT_W     = 6;
  localparam logic [5:0] BITCNT_MAX = 6'h20;
  // config fields
  localparam int FAST_BIT = 0;
  localparam int LATE_BIT = 1;
  // status fields
  localparam int BUSY_BIT   = 0;
  localparam int NOPRES_BIT = 1;
  localparam int STUCK_BIT  = 2;
  // interrupt bits, shared by raw, mask and masked registers
  localparam int IRQ_W           = 5;
  localparam int IRQ_RESET_BIT   = 0;
  localparam int IRQ_OPDONE_BIT  = 1;
  localparam int IRQ_NOPRES_BIT  = 2;
  localparam int IRQ_STUCK_BIT   = 3;
  localparam int IRQ_DMA_BIT     = 4;
  // reset values
  localparam logic [31:0] RXDATA_RST = 32'hffffffff;
  localparam logic [31:0] ZERO_RST   = 32'h00000000;
  // clock and tick
  localparam int CLK_NS   = 5;
  localparam int TICK_NS  = 250;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  // standard speed times in ns
  localparam int STD_RST_LOW_NS  = 480000;
  localparam int STD_PRES_NS     = 550000;
  localparam int STD_RST_SLOT_NS = 960000;
  localparam int STD_SLOT_NS     = 65000;
  localparam int STD_W1_NS       = 6000;
  localparam int STD_W0_NS       = 60000;
  localparam int STD_RDLOW_NS    = 6000;
  localparam int STD_SMP_NS      = 15000;
  localparam int STD_LATE_NS     = 30000;
  // overdrive speed times in ns
  localparam int FST_RST_LOW_NS  = 70000;
  localparam int FST_PRES_NS     = 78500;
  localparam int FST_RST_SLOT_NS = 140000;
  localparam int FST_SLOT_NS     = 10000;
  localparam int FST_W1_NS       = 1000;
  localparam int FST_W0_NS       = 8000;
  localparam int FST_RDLOW_NS    = 1000;
  localparam int FST_SMP_NS      = 2000;
  localparam int FST_LATE_NS     = 3500;
  // tick counts, rounded up to whole ticks
  localparam int TW = 12;
  localparam logic [11:0] STD_RST_LOW_T  = 12'((STD_RST_LOW_NS+TICK_NS-1)/TICK_NS);
  localparam logic [11:0] STD_PRES_T     = 12'((STD_PRES_NS+TICK_NS-1)/TICK_NS);
  localparam logic [11:0] STD_RST_SLOT_T = 12'((STD_RST_SLOT_NS+TICK_NS-1)/TICK_NS);
  localparam logic [11:0] STD_SLOT_T     = 12'((STD_SLOT_NS+TICK_NS-1)/TICK_NS);
  localparam logic [11:0] STD_W1_T       = 12'((STD_W1_NS+TICK_NS-1)/TICK_NS);
  localparam logic [11:0] STD_W0_T       = 12'((STD_W0_NS+TICK_NS-1)/TICK_NS);
  localparam logic [11:0] STD_RDLOW_T    = 12'((STD_RDLOW_NS+TICK_NS-1)/TICK_NS);
  localparam logic [11:0] STD_SMP_T      = 12'((STD_SMP_NS+TICK_NS-1)/TICK_NS);
  localparam logic [11:0] STD_LATE_T     = 12'((STD_LATE_NS+TICK_NS-1)/TICK_NS);
  localparam logic [11:0] FST_RST_LOW_T  = 12'((FST_RST_LOW_NS+TICK_NS-1)/TICK_NS);
  localparam logic [11:0] FST_PRES_T     = 12'((FST_PRES_NS+TICK_NS-1)/TICK_NS);
  localparam logic [11:0] FST_RST_SLOT_T = 12'((FST_RST_SLOT_NS+TICK_NS-1)/TICK_NS);
  localparam logic [11:0] FST_SLOT_T     = 12'((FST_SLOT_NS+TICK_NS-1)/TICK_NS);
  localparam logic [11:0] FST_W1_T       = 12'((FST_W1_NS+TICK_NS-1)/TICK_NS);
  localparam logic [11:0] FST_W0_T       = 12'((FST_W0_NS+TICK_NS-1)/TICK_NS);
  localparam logic [11:0] FST_RDLOW_T    = 12'((FST_RDLOW_NS+TICK_NS-1)/TICK_NS);
  localparam logic [11:0] FST_SMP_T      = 12'((FST_SMP_NS+TICK_NS-1)/TICK_NS);
  localparam logic [11:0] FST_LATE_T     = 12'((FST_LATE_NS+TICK_NS-1)/TICK_NS);
  // bus sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_RESET, ST_WRITE, ST_READ} seq_state_e;
endpackage

// ---- src/tick_gen.sv ----
// tick divider: one-cycle enable pulse every DIV clocks
// assumes a free-running pclk and an asynchronous active-low reset
`timescale 1ns/100ps
module tick_gen #(
  parameter int DIV = owire_pkg::TICK_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      tick_q
);
  logic [15:0] cnt_q;  // cycles since last tick
  logic        wrap;   // divider reached its end

  assign wrap = (cnt_q == 16'(DIV - 1));

  // count up and wrap, pulsing the tick on the wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= wrap ? 16'h0000 : cnt_q + 16'h0001;
      tick_q <= wrap;
    end
  end
endmodule // tick_gen

// ---- src/line_sync.sv ----
// two-flop synchroniser for the bus line sensed at the pin
// assumes the pin is asynchronous to pclk
`timescale 1ns/100ps
module line_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic din,
  output logic      dout_q
);
  logic meta_q;  // first stage, read only by the second

  // idle bus is high, so both stages reset high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b1;
      dout_q <= 1'b1;
    end else begin
      meta_q <= din;
      dout_q <= meta_q;
    end
  end
endmodule // line_sync

// ---- tb/single_wire_bus_master_sva.sv ----
// port checker for the single-wire bus master
// assumes it is bound onto the top module and sees only its ports
`timescale 1ns/100ps
module swbm_checker #(
  parameter int TICK_CYC = 2
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        line_i,
  input wire logic        line_o,
  input wire logic        line_oe,
  input wire logic        dma_done,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  int oe_len;  // cycles the master has pulled the line low so far
  // low-time counter, cleared on release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) oe_len <= 0;
    else oe_len <= line_oe ? oe_len + 1 : 0;
  end
  wire rd_mis = pready && !pwrite && paddr == owire_pkg::MIS_OFS;
  wire wr_done = pready && pwrite;  // write lands at this edge
  property p_rdy_one; pready |=> !pready; endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("pready too long");
  property p_rdy_wait;
    psel && penable && !pready && $past(psel && !penable) |=> pready;
  endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("pready late");
  property p_err_hi; pready && paddr > 8'h1c |-> pslverr; endproperty
  a_err_hi: assert property (p_err_hi) else $error("unmapped accepted");
  property p_err_lo;
    pready && paddr <= 8'h1c |-> pslverr == |paddr[1:0]; endproperty
  a_err_lo: assert property (p_err_lo) else $error("mapped refused");
  property p_err_data; pready && pslverr |-> prdata == 32'h0; endproperty
  a_err_data: assert property (p_err_data) else $error("refused data");
  property p_mis_w; rd_mis |-> prdata[31:5] == 27'h0; endproperty
  a_mis_w: assert property (p_mis_w) else $error("masked bits wide");
  property p_od; line_oe |-> !line_o; endproperty
  a_od: assert property (p_od) else $error("line driven high");
  // each low pulse has one of the slot low widths, in whole ticks
  property p_oe_len;
    $fell(line_oe) |-> oe_len inside {4*TICK_CYC, 24*TICK_CYC,
      32*TICK_CYC, 240*TICK_CYC, 280*TICK_CYC, 1920*TICK_CYC};
  endproperty
  a_oe_len: assert property (p_oe_len) else $error("bad low width");
  property p_irq_hold; irq && !wr_done && !$past(wr_done) |=> irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
  c_slot: cover property ($fell(line_oe));
  c_err: cover property (pready && pslverr);
  c_irq: cover property ($rose(irq));
endmodule // swbm_checker

bind single_wire_bus_master swbm_checker #(.TICK_CYC(TICK_CYC)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .line_i(line_i), .line_o(line_o),
  .line_oe(line_oe), .dma_done(dma_done), .irq(irq));

// ---- tb/bus_slave_model.sv ----
// behavioural slave on the pulled-up line: presence, read zeros, capture
// assumes a 2-cycle tick, so widths below are in pclk cycles
`timescale 1ns/100ps
module bus_slave_model (
  input  wire logic        pclk,
  input  wire logic        line,
  input  wire logic        present,
  input  wire logic        stuck,
  input  wire logic [31:0] rd_data,
  output logic             pull,
  output logic [31:0]      wr_data
);
  int         low_len = 0;     // length of the current low
  int         pres_t  = 0;     // presence countdown
  int         bit_t   = 0;     // zero-bit hold countdown
  logic [4:0] idx     = 5'h0;  // slot index since last bus reset
  logic       line_q  = 1'b1;
  initial wr_data = 32'h0;
  assign pull = stuck || (pres_t > 0 && pres_t <= 700) || bit_t > 0;
  // slot decode; own presence and zero-bit pulls are never taken as a master slot, a stuck pull is
  always @(posedge pclk) begin
    line_q <= line;
    if (pres_t > 0) pres_t <= pres_t - 1;
    if (bit_t > 0) bit_t <= bit_t - 1;
    if (!line && line_q && pres_t == 0 && bit_t == 0) begin
      if (!rd_data[idx]) bit_t <= 300;
      idx <= idx + 5'h1;
    end
    if (!line) low_len <= low_len + 1;
    else if (low_len > 2000) begin
      low_len <= 0;
      idx     <= 5'h0;
      if (present) pres_t <= 730;
    end else if (low_len > 0) begin
      low_len <= 0;
      // short low is a one; presence-length lows are ignored
      if (low_len < 600) wr_data <= {low_len < 400, wr_data[31:1]};
    end
  end
endmodule // bus_slave_model

// ---- tb/single_wire_bus_master_bench.sv ----
// self-checking bench for the single-wire bus master over APB
// assumes the slave model and checker files are compiled before it
`timescale 1ns/100ps
module single_wire_bus_master_bench;
  localparam int TC = 2;  // short tick keeps slots cheap to simulate
  logic        pclk     = 1'b0;
  logic        presetn  = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic        dma_done = 1'b0;
  logic        present  = 1'b1;
  logic        stuck    = 1'b0;
  logic [31:0] rd_data  = 32'hffffffff;
  logic [31:0] q;
  logic        e;
  wire  [31:0] prdata, wr_data;
  wire         pready, pslverr, line_o, line_oe, irq, pull;
  wire         line = !((line_oe && !line_o) || pull);  // pull-up
  int          fails = 0;
  int          checks_done = 0;
  single_wire_bus_master #(.TICK_CYC(TC)) DUT (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line_i(line), .line_o(line_o),
    .line_oe(line_oe), .dma_done(dma_done), .irq(irq));
  bus_slave_model slave (.pclk(pclk), .line(line), .present(present),
    .stuck(stuck), .rd_data(rd_data), .pull(pull), .wr_data(wr_data));
  initial forever #2.5 pclk = ~pclk;
  task automatic stop_test;
    if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer; an idle edge follows so psel is never reassigned
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
    if (n >= 16) begin fails++; stop_test; end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    apb(1'b0, a, 32'h0);
    v = q;
  endtask
  task automatic go(input logic [2:0] ops, input logic [5:0] cnt);
    apb(1'b1, owire_pkg::CTRL_OFS, {10'h0, cnt, 13'h0, ops});
  endtask
  // polls busy, bounded
  task automatic wait_idle;
    int n = 0;
    do begin
      apb(1'b0, owire_pkg::STATUS_OFS, 32'h0);
      n++;
    end while (q[owire_pkg::BUSY_BIT] !== 1'b0 && n < 8000);
    if (n >= 8000) begin fails++; stop_test; end
  endtask
  // reset values, unmapped access, read-only write
  task automatic t_regs;
    logic [31:0] rv [8] = '{32'h00200000, 32'h0, 32'h0, 32'hffffffff,
                            32'h0, 32'h0, 32'h0, 32'h0};
    logic [31:0] v;
    for (int i = 0; i < 8; i++) begin
      rd(8'(i * 4), v);
      chk(v, rv[i]);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    apb(1'b1, owire_pkg::RXDATA_OFS, 32'h0);
    rd(owire_pkg::RXDATA_OFS, v);
    chk(v, 32'hffffffff);
  endtask
  task automatic t_rst_wr;
    logic [31:0] v;
    apb(1'b1, owire_pkg::MASK_OFS, 32'h2);
    apb(1'b1, owire_pkg::TXDATA_OFS, 32'ha5);
    go(3'h3, 6'h08);
    rd(owire_pkg::STATUS_OFS, v);
    chk(v, 32'h1);
    go(3'h4, 6'h01);  // ignored while busy
    wait_idle;
    rd(owire_pkg::RIS_OFS, v);
    chk(v, 32'h3);
    rd(owire_pkg::MIS_OFS, v);
    chk(v, 32'h2);
    chk({31'h0, irq}, 32'h1);
    chk({24'h0, wr_data[31:24]}, 32'ha5);
    apb(1'b1, owire_pkg::RIS_OFS, 32'h3);
    rd(owire_pkg::RIS_OFS, v);
    chk(v, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic t_wr_rd;
    logic [31:0] v;
    rd_data <= 32'hfffffd5f;
    apb(1'b1, owire_pkg::CFG_OFS, 32'h2);
    apb(1'b1, owire_pkg::TXDATA_OFS, 32'h16);
    go(3'h7, 6'h05);
    wait_idle;
    rd(owire_pkg::RXDATA_OFS, v);
    chk(v, 32'hffffffea);
    chk({22'h0, wr_data[31:22]}, 32'h3f6);
    rd(owire_pkg::RIS_OFS, v);
    chk(v, 32'h3);
    apb(1'b1, owire_pkg::RIS_OFS, 32'h3);
    apb(1'b1, owire_pkg::CFG_OFS, 32'h0);
  endtask
  task automatic t_nopres;
    logic [31:0] v;
    present <= 1'b0;
    apb(1'b1, owire_pkg::CFG_OFS, 32'h1);
    go(3'h7, 6'h04);
    wait_idle;
    rd(owire_pkg::RIS_OFS, v);
    chk(v, 32'h5);
    rd(owire_pkg::STATUS_OFS, v);
    chk(v, 32'h2);
    apb(1'b1, owire_pkg::RIS_OFS, 32'h5);
  endtask
  task automatic t_stuck_dma;
    logic [31:0] v;
    stuck <= 1'b1;
    go(3'h2, 6'h01);
    wait_idle;
    rd(owire_pkg::RIS_OFS, v);
    chk(v, 32'h8);
    stuck    <= 1'b0;
    dma_done <= 1'b1;
    @(posedge pclk);
    dma_done <= 1'b0;
    apb(1'b1, owire_pkg::MASK_OFS, 32'h10);
    rd(owire_pkg::RIS_OFS, v);
    chk(v, 32'h18);
    chk({31'h0, irq}, 32'h1);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_rst_wr;
    t_wr_rd;
    t_nopres;
    t_stuck_dma;
    stop_test;
  end
endmodule // single_wire_bus_master_bench
